// *** src/compare_timer_pkg.sv ***
package compare_timer_pkg;

    // ==========================================
    // register byte addresses
    localparam logic [15:0] ADDR_MODE_CTRL = 16'hFFB6;
    localparam logic [15:0] ADDR_FLAGS_CTRL = 16'hFFB7;
    localparam logic [15:0] ADDR_CNT_HIGH = 16'hFFB8;
    localparam logic [15:0] ADDR_CNT_LOW = 16'hFFB9;
    localparam logic [15:0] ADDR_CMP_HIGH = 16'hFFBA;
    localparam logic [15:0] ADDR_CMP_LOW = 16'hFFBB;
    localparam logic [15:0] ADDR_CLK_STOP = 16'hFFFA;

    // ==========================================
    // reset values
    localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] CMP_RESET = 8'hFF;
    localparam logic [7:0] CLK_STOP_RESET = 8'hFF;
    localparam logic [7:0] BYTE_ONES = 8'hFF;
    localparam logic [15:0] WIDE_ONES = 16'hFFFF;

    // ==========================================
    // flag/control register bit positions
    localparam int FLAG_OVF_H = 7;
    localparam int FLAG_CMF_H = 6;
    localparam int FLAG_OVIE_H = 5;
    localparam int FLAG_CCLR_H = 4;
    localparam int FLAG_OVF_L = 3;
    localparam int FLAG_CMF_L = 2;
    localparam int FLAG_OVIE_L = 1;
    localparam int FLAG_CCLR_L = 0;
    // position of this timer's run bit in the clock stop register
    localparam int CLK_STOP_BIT = 2;

    // ==========================================
    // clock select codes
    localparam logic [2:0] SEL_EVENT = 3'h0;
    localparam logic [2:0] SEL_DIV32 = 3'h4;
    localparam logic [2:0] SEL_DIV16 = 3'h5;
    localparam logic [2:0] SEL_DIV4 = 3'h6;
    localparam logic [2:0] SEL_SUB4 = 3'h7;

    // ==========================================
    // prescaler terminal counts
    localparam logic [4:0] DIV32_LAST = 5'h1F;
    localparam logic [3:0] DIV16_LAST = 4'hF;
    localparam logic [1:0] DIV4_LAST = 2'h3;

    typedef struct packed {
        logic high_output_level;
        logic [2:0] high_sel;
        logic low_output_level;
        logic [2:0] low_sel;
    } mode_ctrl_t;

endpackage : compare_timer_pkg

// *** src/dual_mode_compare_timer.sv ***
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
`default_nettype none

// Function
// - wide counter is high byte counter over low byte counter
// - high select top bit 0: one 16-bit counter clocked by low select
// - high select top bit 1: two independent 8-bit counters, own selects
// - 16-bit mode: whole counter clears on match when high clear enable set
// - 16-bit wrap sets high overflow flag; request if overflow enable set
// - 8-bit wrap sets that half's overflow flag; request gated by its enable
// - 8-bit mode: each half clears on own match under its clear enable
// - both compare bytes reset to all ones
// - both counter bytes reset to zero
// - 16-bit compare match sets high match flag and high request together
// - 8-bit match sets that half's match flag and request
// - 16-bit mode: high toggle pin driven by matches, level from control bit
// - 8-bit mode: each toggle pin driven by own match and own level bit
// - writing high output level updates high pin right after the write
// - write-only mode control layout: level, select, level, select; resets zero
// - 16-bit mode wide transfers go through a temporary byte
// - four internal taps: /32, /16, /4, sub/4; low may count event pin
// - 16-bit mode: high counter advances on low counter overflow
// - in low power modes only sub clock /4 keeps counting
// - module standby bit stops the timer
// - flags clear by reading 1 then writing 0; writing 1 does nothing
// - low select: 000 event, 011 prohibited, 1xx /32 /16 /4 sub/4
module dual_mode_compare_timer
    import compare_timer_pkg::*;
(
    input wire logic clk_i, // 200 MHz system clock
    input wire logic reset_i, // synchronous, active high
    input wire logic [15:0] addr_i, // register byte address
    input wire logic [7:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    output logic [7:0] rdata_o, // read data, cycle after rd_i
    input wire logic event_pin_i, // external event pin, async
    input wire logic event_rising_i, // 1 rising, 0 falling edge counted
    input wire logic sub_clk_i, // sub clock, async
    input wire logic low_power_i, // watch, subactive or subsleep
    output logic high_toggle_o, // high toggle pin
    output logic low_toggle_o, // low toggle pin
    output logic high_irq_set_o, // pulse: set high request flag
    output logic low_irq_set_o // pulse: set low request flag
);

    // ==========================================
    // registers
    mode_ctrl_t ctrl_r;
    logic [7:0] flags_r;
    logic [7:0] armed_r;
    logic [7:0] cnt_hi_r;
    logic [7:0] cnt_lo_r;
    logic [7:0] cmp_hi_r;
    logic [7:0] cmp_lo_r;
    logic [7:0] temp_r;
    logic [7:0] clk_stop_r;
    logic [7:0] rdata_r;
    logic high_toggle_r;
    logic low_toggle_r;
    logic high_irq_r;
    logic low_irq_r;
    logic eq_hi_prev_r;
    logic eq_lo_prev_r;
    logic [4:0] pre_r;
    logic [1:0] sub_div_r;
    logic event_meta_r;
    logic event_sync_r;
    logic event_old_r;
    logic sub_meta_r;
    logic sub_sync_r;
    logic sub_old_r;

    // ==========================================
    // decode
    logic wide;
    logic run;
    logic wr_ctrl;
    logic wr_flags;
    logic wr_cnt_hi;
    logic wr_cnt_lo;
    logic wr_cmp_hi;
    logic wr_cmp_lo;
    logic rd_flags;

    assign wide = !ctrl_r.high_sel[2];
    assign run = clk_stop_r[CLK_STOP_BIT];
    assign wr_ctrl = wr_i && (addr_i == ADDR_MODE_CTRL);
    assign wr_flags = wr_i && (addr_i == ADDR_FLAGS_CTRL);
    assign wr_cnt_hi = wr_i && (addr_i == ADDR_CNT_HIGH);
    assign wr_cnt_lo = wr_i && (addr_i == ADDR_CNT_LOW);
    assign wr_cmp_hi = wr_i && (addr_i == ADDR_CMP_HIGH);
    assign wr_cmp_lo = wr_i && (addr_i == ADDR_CMP_LOW);
    assign rd_flags = rd_i && (addr_i == ADDR_FLAGS_CTRL);

    // ==========================================
    // pin synchronisers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            event_meta_r <= 1'b0;
            event_sync_r <= 1'b0;
            event_old_r <= 1'b0;
        end else begin
            event_meta_r <= event_pin_i;
            event_sync_r <= event_meta_r;
            event_old_r <= event_sync_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sub_meta_r <= 1'b0;
            sub_sync_r <= 1'b0;
            sub_old_r <= 1'b0;
        end else begin
            sub_meta_r <= sub_clk_i;
            sub_sync_r <= sub_meta_r;
            sub_old_r <= sub_sync_r;
        end
    end

    logic event_edge;
    logic sub_rise;

    assign event_edge = event_rising_i ? (event_sync_r && !event_old_r)
                                       : (!event_sync_r && event_old_r);
    assign sub_rise = sub_sync_r && !sub_old_r;

    // ==========================================
    // prescalers
    // free running: tap phase is not reset by a select change
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pre_r <= 5'h00;
        end else begin
            pre_r <= pre_r + 5'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sub_div_r <= 2'h0;
        end else if (sub_rise) begin
            sub_div_r <= sub_div_r + 2'h1;
        end
    end

    logic tick32;
    logic tick16;
    logic tick4;
    logic tick_sub;

    assign tick32 = (pre_r == DIV32_LAST);
    assign tick16 = (pre_r[3:0] == DIV16_LAST);
    assign tick4 = (pre_r[1:0] == DIV4_LAST);
    assign tick_sub = sub_rise && (sub_div_r == DIV4_LAST);

    // ==========================================
    // clock selection
    function automatic logic sel_tick(input logic [2:0] sel, input logic allow_event,
                                      input logic ev, input logic t32, input logic t16,
                                      input logic t4, input logic ts, input logic lp);
        logic t;
        t = 1'b0;
        case (sel)
            SEL_EVENT: t = allow_event && ev;
            SEL_DIV32: t = t32;
            SEL_DIV16: t = t16;
            SEL_DIV4: t = t4;
            SEL_SUB4: t = ts;
            default: t = 1'b0;
        endcase
        if (lp && (sel != SEL_SUB4)) begin
            t = 1'b0;
        end
        return t;
    endfunction : sel_tick

    logic lo_tick;
    logic hi_tick8;

    assign lo_tick = run && sel_tick(ctrl_r.low_sel, 1'b1, event_edge, tick32,
                                     tick16, tick4, tick_sub, low_power_i);
    assign hi_tick8 = run && sel_tick(ctrl_r.high_sel, 1'b0, event_edge, tick32,
                                      tick16, tick4, tick_sub, low_power_i);

    // ==========================================
    // compare
    logic eq_hi;
    logic eq_lo;
    logic match_hi_ev;
    logic match_lo_ev;

    assign eq_hi = wide ? ({cnt_hi_r, cnt_lo_r} == {cmp_hi_r, cmp_lo_r})
                        : (cnt_hi_r == cmp_hi_r);
    assign eq_lo = !wide && (cnt_lo_r == cmp_lo_r);
    // event on entering equality, so a held match counts once
    assign match_hi_ev = eq_hi && !eq_hi_prev_r;
    assign match_lo_ev = eq_lo && !eq_lo_prev_r;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            eq_hi_prev_r <= 1'b0;
            eq_lo_prev_r <= 1'b0;
        end else begin
            eq_hi_prev_r <= eq_hi;
            eq_lo_prev_r <= eq_lo;
        end
    end

    // ==========================================
    // counting
    logic lo_clr;
    logic hi_clr8;
    logic hi_tick;
    logic ovf_hi_ev;
    logic ovf_lo_ev;

    assign lo_clr = wide ? (eq_hi && flags_r[FLAG_CCLR_H])
                         : (eq_lo && flags_r[FLAG_CCLR_L]);
    assign hi_clr8 = eq_hi && flags_r[FLAG_CCLR_H];
    assign hi_tick = wide ? (lo_tick && (cnt_lo_r == BYTE_ONES) && !lo_clr)
                          : hi_tick8;
    assign ovf_hi_ev = wide
        ? (lo_tick && ({cnt_hi_r, cnt_lo_r} == WIDE_ONES) && !lo_clr)
        : (hi_tick8 && (cnt_hi_r == BYTE_ONES) && !hi_clr8);
    assign ovf_lo_ev = !wide && lo_tick && (cnt_lo_r == BYTE_ONES) && !lo_clr;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cnt_lo_r <= CNT_RESET;
        end else if (wr_cnt_lo) begin
            cnt_lo_r <= wdata_i;
        end else if (lo_tick) begin
            cnt_lo_r <= lo_clr ? CNT_RESET : cnt_lo_r + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cnt_hi_r <= CNT_RESET;
        end else if (wr_cnt_lo && wide) begin
            cnt_hi_r <= temp_r;
        end else if (wr_cnt_hi && !wide) begin
            cnt_hi_r <= wdata_i;
        end else if (wide && lo_tick && lo_clr) begin
            cnt_hi_r <= CNT_RESET;
        end else if (hi_tick) begin
            cnt_hi_r <= (!wide && hi_clr8) ? CNT_RESET : cnt_hi_r + 8'h01;
        end
    end

    // ==========================================
    // compare bytes
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cmp_lo_r <= CMP_RESET;
        end else if (wr_cmp_lo) begin
            cmp_lo_r <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cmp_hi_r <= CMP_RESET;
        end else if (wr_cmp_lo && wide) begin
            cmp_hi_r <= temp_r;
        end else if (wr_cmp_hi && !wide) begin
            cmp_hi_r <= wdata_i;
        end
    end

    // ==========================================
    // temporary byte
    // high byte first on write, high byte first on read
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            temp_r <= 8'h00;
        end else if (wide && (wr_cnt_hi || wr_cmp_hi)) begin
            temp_r <= wdata_i;
        end else if (wide && rd_i && (addr_i == ADDR_CNT_HIGH)) begin
            temp_r <= cnt_lo_r;
        end else if (wide && rd_i && (addr_i == ADDR_CMP_HIGH)) begin
            temp_r <= cmp_lo_r;
        end
    end

    // ==========================================
    // mode control and standby
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctrl_r <= mode_ctrl_t'(MODE_CTRL_RESET);
        end else if (wr_ctrl) begin
            ctrl_r <= mode_ctrl_t'(wdata_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            clk_stop_r <= CLK_STOP_RESET;
        end else if (wr_i && (addr_i == ADDR_CLK_STOP)) begin
            clk_stop_r <= wdata_i;
        end
    end

    // ==========================================
    // flags and enables
    logic [7:0] set_ev;

    always_comb begin
        set_ev = 8'h00;
        set_ev[FLAG_OVF_H] = ovf_hi_ev;
        set_ev[FLAG_CMF_H] = match_hi_ev;
        set_ev[FLAG_OVF_L] = ovf_lo_ev;
        set_ev[FLAG_CMF_L] = match_lo_ev;
    end

    // a flag may only be cleared after it was seen as 1
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            armed_r <= 8'h00;
        end else if (rd_flags) begin
            armed_r <= flags_r;
        end else if (wr_flags) begin
            armed_r <= 8'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            flags_r <= FLAGS_RESET;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (set_ev[i]) begin
                    flags_r[i] <= 1'b1; // set wins over clear
                end else if (wr_flags) begin
                    if ((i == FLAG_OVF_H) || (i == FLAG_CMF_H) ||
                        (i == FLAG_OVF_L) || (i == FLAG_CMF_L)) begin
                        if (!wdata_i[i] && armed_r[i]) begin
                            flags_r[i] <= 1'b0;
                        end
                    end else begin
                        flags_r[i] <= wdata_i[i];
                    end
                end
            end
        end
    end

    // ==========================================
    // request pulses to the interrupt controller
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            high_irq_r <= 1'b0;
            low_irq_r <= 1'b0;
        end else begin
            high_irq_r <= match_hi_ev || (ovf_hi_ev && flags_r[FLAG_OVIE_H]);
            low_irq_r <= match_lo_ev || (ovf_lo_ev && flags_r[FLAG_OVIE_L]);
        end
    end

    // ==========================================
    // toggle outputs
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            high_toggle_r <= 1'b0;
        end else if (wr_ctrl) begin
            high_toggle_r <= wdata_i[7];
        end else if (match_hi_ev) begin
            high_toggle_r <= !high_toggle_r;
        end
    end

    // in 16-bit mode the low pin just holds its level
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            low_toggle_r <= 1'b0;
        end else if (wr_ctrl) begin
            low_toggle_r <= wdata_i[3];
        end else if (match_lo_ev) begin
            low_toggle_r <= !low_toggle_r;
        end
    end

    // ==========================================
    // read port
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_r <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                ADDR_FLAGS_CTRL: rdata_r <= flags_r;
                ADDR_CNT_HIGH: rdata_r <= cnt_hi_r;
                ADDR_CNT_LOW: rdata_r <= wide ? temp_r : cnt_lo_r;
                ADDR_CMP_HIGH: rdata_r <= cmp_hi_r;
                ADDR_CMP_LOW: rdata_r <= wide ? temp_r : cmp_lo_r;
                ADDR_CLK_STOP: rdata_r <= clk_stop_r;
                default: rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign rdata_o = rdata_r;
    assign high_toggle_o = high_toggle_r;
    assign low_toggle_o = low_toggle_r;
    assign high_irq_set_o = high_irq_r;
    assign low_irq_set_o = low_irq_r;

endmodule : dual_mode_compare_timer

`default_nettype wire

// *** tb/timer_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module timer_props
    import compare_timer_pkg::*;
(
    input wire logic clk_i, // clock
    input wire logic reset_i, // sync reset
    input wire logic [15:0] addr_i, // address
    input wire logic [7:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    input wire logic [7:0] rdata_o, // read data
    input wire logic high_toggle_o, // high pin
    input wire logic low_toggle_o, // low pin
    input wire logic high_irq_set_o, // high request pulse
    input wire logic low_irq_set_o // low request pulse
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    // ==========
    // helpers
    logic wide_mode_r;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wide_mode_r <= 1'b1;
        end else if (wr_i && addr_i == ADDR_MODE_CTRL) begin
            wide_mode_r <= !wdata_i[6];
        end
    end
    sequence mode_wr;
        wr_i && addr_i == ADDR_MODE_CTRL;
    endsequence
    sequence no_mode_wr;
        !(wr_i && addr_i == ADDR_MODE_CTRL);
    endsequence
    sequence stop_wr_rd;
        wr_i && addr_i == ADDR_CLK_STOP ##1 rd_i && addr_i == ADDR_CLK_STOP;
    endsequence
    // ==========
    // assertions
    reset_outputs_a: assert property (disable iff (1'b0)
        reset_i |=> !high_toggle_o && !low_toggle_o && rdata_o == 8'h00)
        else $error("outputs not cleared by reset");
    mode_read_zero_a: assert property (
        rd_i && addr_i == ADDR_MODE_CTRL |=> rdata_o == 8'h00)
        else $error("mode control readable");
    high_level_write_a: assert property (mode_wr |=> high_toggle_o == $past(wdata_i[7]))
        else $error("high pin missed level write");
    low_level_write_a: assert property (mode_wr |=> low_toggle_o == $past(wdata_i[3]))
        else $error("low pin missed level write");
    // pin flip and request pulse leave the same edge
    high_flip_irq_a: assert property (
        no_mode_wr ##1 $changed(high_toggle_o) |-> high_irq_set_o)
        else $error("high pin flip without match request");
    low_flip_irq_a: assert property (
        no_mode_wr ##1 $changed(low_toggle_o) |-> low_irq_set_o)
        else $error("low pin flip without match request");
    wide_low_hold_a: assert property (wide_mode_r ##0 no_mode_wr |=> $stable(low_toggle_o))
        else $error("low pin moved in wide mode");
    standby_readback_a: assert property (stop_wr_rd |=> rdata_o == $past(wdata_i, 2))
        else $error("clock stop readback wrong");
endmodule : timer_props
bind dual_mode_compare_timer timer_props u_timer_props (.clk_i(clk_i), .reset_i(reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .high_toggle_o(high_toggle_o), .low_toggle_o(low_toggle_o),
    .high_irq_set_o(high_irq_set_o), .low_irq_set_o(low_irq_set_o));
`default_nettype wire

// *** tb/event_source.sv ***
`timescale 1ns/10ps
`default_nettype none
module event_source (
    output logic event_pin_o, // event pin
    output logic sub_clk_o // sub clock
);
    // ==========
    // sub oscillator free running, phase unrelated to the system clock
    initial begin
        sub_clk_o = 1'b0;
        forever #15.3 sub_clk_o = ~sub_clk_o;
    end
    initial event_pin_o = 1'b0;
    // slow pulses so the two-flop synchroniser sees every edge
    task automatic pulses(input int n);
        repeat (n) begin
            #40 event_pin_o = 1'b1;
            #40 event_pin_o = 1'b0;
        end
    endtask : pulses
endmodule : event_source
`default_nettype wire

// *** tb/dual_mode_compare_timer_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module dual_mode_compare_timer_bench;
    import compare_timer_pkg::*;
    logic clk_i, reset_i, wr_i, rd_i, event_rising_i, low_power_i, event_pin_i, sub_clk_i;
    logic high_toggle_o, low_toggle_o, high_irq_set_o, low_irq_set_o;
    logic [15:0] addr_i;
    logic [7:0] wdata_i, rdata_o;
    int fails, check_count;
    dual_mode_compare_timer u_dual_mode_compare_timer (.clk_i(clk_i), .reset_i(reset_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .event_pin_i(event_pin_i), .event_rising_i(event_rising_i), .sub_clk_i(sub_clk_i),
        .low_power_i(low_power_i), .high_toggle_o(high_toggle_o), .low_toggle_o(low_toggle_o),
        .high_irq_set_o(high_irq_set_o), .low_irq_set_o(low_irq_set_o));
    event_source u_event_source (.event_pin_o(event_pin_i), .sub_clk_o(sub_clk_i));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // ==========
    // bus and checking tasks
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done
    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_byte
    task automatic chk_pin(input logic g, input logic e);
        chk_byte({7'h00, g}, {7'h00, e});
    endtask : chk_pin
    task automatic idle(input int n);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        repeat (n) @(posedge clk_i);
    endtask : idle
    // strobes stay up so a following access can go back to back
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        wr_i <= 1'b1;
        rd_i <= 1'b0;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
    endtask : wr
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        // data stands for this one cycle only; look mid-cycle
        @(negedge clk_i);
        chk_byte(rdata_o, e);
        @(posedge clk_i);
    endtask : rd_chk
    task automatic wait_irq(input logic hi, input int bound);
        int n;
        n = 0;
        idle(1);
        @(negedge clk_i);
        while ((hi ? high_irq_set_o : low_irq_set_o) !== 1'b1) begin
            n++;
            if (n > bound) begin
                fails++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
                test_done();
            end
            @(negedge clk_i);
        end
        @(posedge clk_i);
    endtask : wait_irq
    task automatic do_reset;
        reset_i <= 1'b1;
        idle(12);
        reset_i <= 1'b0;
        @(posedge clk_i);
    endtask : do_reset
    // ==========
    // scenarios
    task automatic t_registers;
        logic [7:0] e [6] = '{8'h00, FLAGS_RESET, CNT_RESET, CNT_RESET, CMP_RESET, CMP_RESET};
        do_reset();
        for (int i = 0; i < 6; i++) begin
            rd_chk(ADDR_MODE_CTRL + 16'(i), e[i]);
        end
        rd_chk(ADDR_CLK_STOP, CLK_STOP_RESET);
        rd_chk(16'hFFB5, 8'h00);
        wr(ADDR_MODE_CTRL, 8'h88);
        idle(1);
        chk_pin(high_toggle_o, 1'b1);
        chk_pin(low_toggle_o, 1'b1);
        wr(ADDR_MODE_CTRL, 8'h00);
        rd_chk(ADDR_MODE_CTRL, 8'h00);
        chk_pin(high_toggle_o, 1'b0);
        wr(ADDR_CLK_STOP, 8'h5A);
        rd_chk(ADDR_CLK_STOP, 8'h5A);
        $display("registers done");
    endtask : t_registers
    task automatic t_byte_match;
        do_reset();
        wr(ADDR_MODE_CTRL, 8'h66);
        wr(ADDR_CMP_LOW, 8'h03);
        wr(ADDR_FLAGS_CTRL, 8'h01);
        wait_irq(1'b0, 100);
        chk_pin(low_toggle_o, 1'b1);
        chk_pin(high_toggle_o, 1'b0);
        wait_irq(1'b0, 40);
        chk_pin(low_toggle_o, 1'b0);
        wr(ADDR_FLAGS_CTRL, 8'h01);
        rd_chk(ADDR_FLAGS_CTRL, 8'h05);
        $display("byte match done");
    endtask : t_byte_match
    task automatic t_wide_overflow;
        do_reset();
        wr(ADDR_FLAGS_CTRL, 8'h20);
        wr(ADDR_CNT_HIGH, 8'hFF);
        wr(ADDR_CNT_LOW, 8'hF0);
        wr(ADDR_MODE_CTRL, 8'h06);
        wait_irq(1'b1, 120);
        chk_pin(high_toggle_o, 1'b1);
        wait_irq(1'b1, 20);
        rd_chk(ADDR_FLAGS_CTRL, 8'hE0);
        rd_chk(ADDR_CNT_HIGH, 8'h00);
        wr(ADDR_FLAGS_CTRL, 8'h00);
        rd_chk(ADDR_FLAGS_CTRL, 8'h00);
        wr(ADDR_FLAGS_CTRL, 8'hC4);
        rd_chk(ADDR_FLAGS_CTRL, 8'h00);
        wr(ADDR_CMP_HIGH, 8'h12);
        wr(ADDR_CMP_LOW, 8'h34);
        wr(ADDR_CMP_HIGH, 8'h56);
        rd_chk(ADDR_CMP_HIGH, 8'h12);
        rd_chk(ADDR_CMP_LOW, 8'h34);
        $display("wide overflow done");
    endtask : t_wide_overflow
    task automatic t_event_count;
        do_reset();
        wr(ADDR_MODE_CTRL, 8'h40);
        wr(ADDR_CNT_LOW, 8'hFD);
        wr(ADDR_FLAGS_CTRL, 8'h02);
        idle(1);
        u_event_source.pulses(4);
        @(posedge clk_i);
        idle(10);
        rd_chk(ADDR_CNT_LOW, 8'h01);
        rd_chk(ADDR_FLAGS_CTRL, 8'h0E);
        chk_pin(low_toggle_o, 1'b1);
        // switch edge only once the last fall has left the synchroniser
        event_rising_i <= 1'b0;
        u_event_source.pulses(2);
        @(posedge clk_i);
        idle(10);
        rd_chk(ADDR_CNT_LOW, 8'h03);
        $display("event count done");
    endtask : t_event_count
    task automatic t_halt;
        do_reset();
        low_power_i <= 1'b1;
        wr(ADDR_MODE_CTRL, 8'h66);
        idle(40);
        rd_chk(ADDR_CNT_LOW, 8'h00);
        wr(ADDR_CLK_STOP, 8'hFB);
        low_power_i <= 1'b0;
        idle(40);
        rd_chk(ADDR_CNT_LOW, 8'h00);
        $display("halt done");
    endtask : t_halt
    initial begin
        reset_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 16'h0000;
        wdata_i = 8'h00;
        event_rising_i = 1'b1;
        low_power_i = 1'b0;
        fails = 0;
        check_count = 0;
        t_registers();
        t_byte_match();
        t_wide_overflow();
        t_event_count();
        t_halt();
        test_done();
    end
endmodule : dual_mode_compare_timer_bench
`default_nettype wire
